// >>> test/test_uaf_core.sv
`timescale 1ns/10ps
module test_uaf_core;
  logic        i_clk = 1'b0;
  logic        i_rst = 1'b1;
  logic [4:0]  addr  = 5'h00;
  logic [31:0] wdat  = 32'h0;
  logic        rd    = 1'b0;
  logic        wr    = 1'b0;
  logic        go    = 1'b0;
  logic        extra = 1'b0;
  logic        hold  = 1'b1;
  logic [31:0] rdat;
  logic        wreq;
  logic        serial_input_line;
  logic        sout;
  logic        cts_n;
  logic        rts_n;
  logic        rxd_n;
  logic        txd_n;
  logic        baud;
  logic [7:0]  sent;
  logic [7:0]  q;
  logic [7:0]  nb = 8'h00;
  int          errors = 0;
  int          n_compared = 0;
  uaf_core u_dut (.i_clk(i_clk), .i_rst(i_rst), .i_avs_address(addr), .i_avs_read(rd),
    .i_avs_write(wr), .i_avs_writedata(wdat), .i_avs_byteenable(4'h1), .o_avs_readdata(rdat),
    .o_avs_waitrequest(wreq), .i_serial_input_line(serial_input_line), .o_serial_output_line(sout),
    .i_cts_n(cts_n), .o_rts_n(rts_n), .o_dtr_n(), .o_tx_dma_request_n(txd_n),
    .o_rx_dma_request_n(rxd_n), .o_baud_clock_output(baud));
  uaf_far_model u_far (.i_clk(i_clk), .i_tick(baud), .i_go(go), .i_extra(extra), .i_hold(hold),
    .i_rts_n(rts_n), .o_line(serial_input_line), .o_cts_n(cts_n), .o_sent(sent));
  initial forever #5 i_clk = ~i_clk;
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d);
    addr <= a;
    wdat <= {24'h0, d};
    rd <= !w;
    wr <= w;
    do @(posedge i_clk); while (wreq !== 1'b0);
    q = rdat[7:0];
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge i_clk);
  endtask : bus
  task automatic rts_is(input logic v);
    chk("rts_n", {7'h0, v}, {7'h0, rts_n});
  endtask : rts_is
  task automatic wait_rts(input logic v);
    int n;
    n = 0;
    while (rts_n !== v && n < 6000) begin
      @(posedge i_clk);
      n++;
    end
    rts_is(v);
  endtask : wait_rts
  task automatic drain(input int k);
    repeat (k) begin
      bus(1'b0, 5'h00, 8'h00);
      chk("rx byte", 8'h30 + nb, q);
      nb++;
    end
  endtask : drain
  // samples mid-bit; h is applied to cts before the stop bit
  task automatic frame(input logic h, input logic [7:0] e);
    int n;
    logic [7:0] b;
    n = 0;
    while (sout !== 1'b0 && n < 3000) begin
      @(posedge i_clk);
      n++;
    end
    repeat (8) @(posedge i_clk);
    for (int i = 0; i < 8; i++) begin
      repeat (16) @(posedge i_clk);
      b[i] = sout;
      hold <= h;
    end
    chk("tx byte", e, b);
    repeat (16) @(posedge i_clk);
    chk("stop", 8'h01, {7'h0, sout});
  endtask : frame
  task automatic quiet();
    int n;
    n = 0;
    repeat (300) begin
      @(posedge i_clk);
      if (sout !== 1'b1) n++;
    end
    chk("quiet", 8'h00, {7'h0, n != 0});
  endtask : quiet
  task automatic set_div(input logic [7:0] v);
    bus(1'b1, 5'h0c, 8'h80);
    bus(1'b1, 5'h00, v);
    bus(1'b1, 5'h04, 8'h00);
    bus(1'b1, 5'h0c, 8'h03);
  endtask : set_div
  task automatic t_regs();
    int n;
    bus(1'b0, 5'h08, 8'h00);
    chk("iir", 8'h01, q);
    bus(1'b0, 5'h10, 8'h00);
    chk("mcr", 8'h00, q);
    bus(1'b1, 5'h1c, 8'ha5);
    bus(1'b0, 5'h1f, 8'h00);
    chk("scratch", 8'ha5, q);
    set_div(8'h03);
    n = 0;
    repeat (30) begin
      @(posedge i_clk);
      n += baud;
    end
    chk("ticks", 8'h0a, n[7:0]);
    set_div(8'h01);
    bus(1'b1, 5'h08, 8'h01);
    bus(1'b0, 5'h08, 8'h00);
    chk("iir", 8'hc1, q);
    $display("test regs done");
  endtask : t_regs
  task automatic t_trig4();
    bus(1'b1, 5'h08, 8'h41);
    bus(1'b1, 5'h10, 8'h22);
    extra <= 1'b1;
    go <= 1'b1;
    wait_rts(1'b1);
    chk("sent", nb + 8'h04, sent);
    repeat (400) @(posedge i_clk);
    go <= 1'b0;
    extra <= 1'b0;
    chk("sent", nb + 8'h05, sent);
    bus(1'b0, 5'h14, 8'h00);
    chk("lsr", 8'h01, q & 8'h03);
    chk("rx dma", 8'h00, {7'h0, rxd_n});
    drain(4);
    rts_is(1'b1);
    drain(1);
    repeat (2) @(posedge i_clk);
    rts_is(1'b0);
    chk("rx dma", 8'h01, {7'h0, rxd_n});
    $display("test trigger four done");
  endtask : t_trig4
  task automatic t_trig14();
    bus(1'b1, 5'h08, 8'hc1);
    go <= 1'b1;
    wait_rts(1'b1);
    go <= 1'b0;
    chk("sent", nb + 8'h10, sent);
    repeat (200) @(posedge i_clk);
    rts_is(1'b1);
    drain(1);
    repeat (2) @(posedge i_clk);
    rts_is(1'b0);
    repeat (50) @(posedge i_clk);
    rts_is(1'b0);
    drain(15);
    $display("test trigger fourteen done");
  endtask : t_trig14
  task automatic t_cts();
    bus(1'b1, 5'h10, 8'h20);
    bus(1'b1, 5'h00, 8'h5a);
    quiet();
    rts_is(1'b1);
    chk("tx dma", 8'h01, {7'h0, txd_n});
    bus(1'b0, 5'h18, 8'h00);
    chk("msr", 8'h00, q);
    hold <= 1'b0;
    frame(1'b0, 8'h5a);
    chk("tx dma", 8'h00, {7'h0, txd_n});
    bus(1'b0, 5'h18, 8'h00);
    chk("msr", 8'h11, q);
    bus(1'b0, 5'h18, 8'h00);
    chk("msr", 8'h10, q);
    bus(1'b1, 5'h00, 8'h11);
    bus(1'b1, 5'h00, 8'h22);
    frame(1'b1, 8'h11);
    quiet();
    hold <= 1'b0;
    frame(1'b0, 8'h22);
    bus(1'b1, 5'h10, 8'h02);
    hold <= 1'b1;
    bus(1'b1, 5'h00, 8'h77);
    frame(1'b1, 8'h77);
    rts_is(1'b0);
    $display("test cts done");
  endtask : t_cts
  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : give_verdict
  initial begin
    repeat (4) @(posedge i_clk);
    i_rst <= 1'b0;
    @(posedge i_clk);
    t_regs();
    t_trig4();
    t_trig14();
    t_cts();
    give_verdict();
  end
  initial begin
    repeat (40000) @(posedge i_clk);
    errors++;
    give_verdict();
  end
endmodule : test_uaf_core

// >>> test/uaf_core_checker.sv
`timescale 1ns/10ps
module uaf_core_checker
  import uaf_pkg::*;
(
  // watched ports
  input wire logic        i_clk,
  input wire logic        i_rst,
  input wire logic [4:0]  i_avs_address,
  input wire logic        i_avs_read,
  input wire logic        i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0]  i_avs_byteenable,
  input wire logic [31:0] o_avs_readdata,
  input wire logic        o_avs_waitrequest,
  input wire logic        i_cts_n,
  input wire logic        o_rts_n,
  input wire logic        o_dtr_n,
  input wire logic        o_serial_output_line,
  input wire logic        o_baud_clock_output
);
  logic [7:0]  lcr_q;
  logic [15:0] div_q;
  logic [7:0]  mcr_q;
  logic        fen_q;
  logic [3:0]  cts_q;
  logic [7:0]  hi_q;
  logic        wr_ok;
  logic        auto_c;
  logic        rd_ok;
  logic [7:0]  wd;
  assign wd = i_avs_writedata[7:0];
  assign wr_ok = i_avs_write && !o_avs_waitrequest && i_avs_byteenable[0];
  assign rd_ok = i_avs_read && !o_avs_waitrequest;
  assign auto_c = mcr_q[MCR_AFE_BIT] && fen_q;
  // shadow of the few registers the properties depend on
  always_ff @(posedge i_clk) begin
    cts_q <= {cts_q[2:0], i_cts_n};
    if (i_rst) begin
      lcr_q <= 8'h00;
      div_q <= 16'h0000;
      mcr_q <= 8'h00;
      fen_q <= 1'b0;
      hi_q  <= 8'h00;
    end else begin
      hi_q <= (auto_c && i_cts_n) ? hi_q + {7'h00, hi_q != 8'hff} : 8'h00;
      if (wr_ok) begin
        case (i_avs_address[4:2])
          REG_DATA: if (lcr_q[LCR_DLAB_BIT]) div_q[7:0] <= wd;
          REG_IER:  if (lcr_q[LCR_DLAB_BIT]) div_q[15:8] <= wd;
          REG_FCR:  fen_q <= wd[FCR_EN_BIT];
          REG_LCR:  lcr_q <= wd;
          REG_MCR:  mcr_q <= wd;
          default:  ;
        endcase
      end
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  a_reset_vals: assert property ($past(i_rst) |-> o_avs_waitrequest && o_rts_n && o_dtr_n
    && o_serial_output_line && !o_baud_clock_output) else $error("outputs not idle after reset");
  a_rts_off: assert property (!mcr_q[MCR_RTS_BIT] && !$past(mcr_q[MCR_RTS_BIT]) |-> o_rts_n)
    else $error("rts asserted while its control bit is clear");
  a_rts_manual: assert property (mcr_q[MCR_RTS_BIT] && $past(mcr_q[MCR_RTS_BIT]) && !auto_c
    && !$past(auto_c) |-> !o_rts_n) else $error("rts not following control bit");
  a_iir_mode: assert property (rd_ok && i_avs_address[4:2] == REG_FCR
    |-> o_avs_readdata[7:0] == (fen_q ? IIR_FIFO : IIR_CHAR)) else $error("mode readback wrong");
  a_cts_level: assert property (rd_ok && i_avs_address[4:2] == REG_MSR && cts_q == {4{i_cts_n}}
    |-> o_avs_readdata[MSR_CTS_BIT] == !i_cts_n) else $error("cts level readback wrong");
  a_baud_idle: assert property (div_q == 16'h0000 && $past(div_q) == 16'h0000
    |-> !o_baud_clock_output) else $error("baud tick with zero divisor");
  a_baud_pulse: assert property (o_baud_clock_output && div_q > 16'h0001
    |=> !o_baud_clock_output) else $error("baud tick longer than one cycle");
  a_cts_hold: assert property (hi_q > 8'hc8 && div_q == 16'h0001 && !lcr_q[LCR_BRK_BIT]
    |-> o_serial_output_line) else $error("transmit while cts deasserted");
endmodule : uaf_core_checker

bind uaf_core uaf_core_checker u_chk (
  .i_clk(i_clk), .i_rst(i_rst), .i_avs_address(i_avs_address), .i_avs_read(i_avs_read),
  .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata), .i_avs_byteenable(i_avs_byteenable),
  .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest), .i_cts_n(i_cts_n),
  .o_rts_n(o_rts_n), .o_dtr_n(o_dtr_n), .o_serial_output_line(o_serial_output_line),
  .o_baud_clock_output(o_baud_clock_output)
);

// >>> test/uaf_far_model.sv
`timescale 1ns/10ps
module uaf_far_model (
  // clock and 16x tick
  input  wire logic       i_clk,
  input  wire logic       i_tick,
  // bench controls
  input  wire logic       i_go,
  input  wire logic       i_extra,
  input  wire logic       i_hold,
  // serial side
  input  wire logic       i_rts_n,
  output logic            o_line,
  output logic            o_cts_n,
  output logic [7:0]      o_sent
);
  logic [10:0] frm = 11'h7ff;
  logic [7:0]  tk = 8'h00;
  logic        used = 1'b0;
  initial o_cts_n = 1'b1;
  initial o_sent = 8'h00;
  assign o_line = frm[0];
  always @(posedge i_clk) begin
    o_cts_n <= i_hold;
    if (!i_extra) used <= 1'b0;
    if (tk != 8'h00) begin
      if (i_tick) tk <= tk - 8'h01;
      if (i_tick && tk[3:0] == 4'h1) frm <= {1'b1, frm[10:1]};
    end else if (i_go && (!i_rts_n || (i_extra && !used))) begin
      // extra lets one byte go after rts drops, as a late sender would
      if (i_rts_n) used <= 1'b1;
      frm <= {2'b11, 8'h30 + o_sent, 1'b0};
      tk <= 8'hb0;
      o_sent <= o_sent + 8'h01;
    end
  end
endmodule : uaf_far_model

// >>> verilog/uaf_baud_gen.sv
`timescale 1ns/10ps
module uaf_baud_gen
  import uaf_pkg::*;
(
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  // divisor; zero holds the generator still
  input  wire logic [15:0] i_divisor,
  // one pulse per 16x period
  output logic             o_tick
);

  typedef struct packed {
    logic [15:0] cnt;
    logic        tick;
  } uaf_baud_st_t;

  uaf_baud_st_t q;
  uaf_baud_st_t d;

  always_comb begin
    d      = q;
    d.tick = 1'b0;
    if (i_divisor == '0) begin
      d.cnt = '0;
    end else if (q.cnt >= i_divisor - 16'h0001) begin
      d.cnt  = '0;
      d.tick = 1'b1;
    end else begin
      d.cnt = q.cnt + 16'h0001;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign o_tick = q.tick;

endmodule : uaf_baud_gen

// >>> verilog/uaf_core.sv
`timescale 1ns/10ps
// Overview of operation
// - auto-CTS: no byte starts unless CTS asserted
// - trigger 1/4/8: drop RTS at trigger level
// - accept one more byte after RTS drops
// - trigger 1/4/8: raise RTS when fifo empty
// - trigger 14: drop RTS on 16th byte
// - trigger 14: raise RTS when space frees
// - trigger 14: read at full raises RTS
// - sample CTS before starting each byte
// - CTS changes raise no host interrupt
// - without auto-CTS, ignore CTS level
// - MCR bit 5 enables auto-CTS, bits 5 and 1 auto-RTS
// - autoflow works only in fifo mode
// - 16-byte fifos, three rx error bits
// - divisor 1..65535 gives 16x tick
// - reset in character mode, fifo switchable
// - tx and rx dma request outputs
// - 5-8 bits, parity, 1/1.5/2 stops
// - MSR bit0 CTS change, bit4 level
module uaf_core
  import uaf_pkg::*;
(
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  // avalon-mm slave
  input  wire logic [4:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  input  wire logic [3:0]  i_avs_byteenable,
  output logic      [31:0] o_avs_readdata,
  output logic             o_avs_waitrequest,
  // serial side
  input  wire logic        i_serial_input_line,
  output logic             o_serial_output_line,
  input  wire logic        i_cts_n,
  output logic             o_rts_n,
  output logic             o_dtr_n,
  // dma requests and baud clock
  output logic             o_tx_dma_request_n,
  output logic             o_rx_dma_request_n,
  output logic             o_baud_clock_output
);

  typedef struct packed {
    logic                waitreq;
    logic [7:0]          rdata;
    logic [3:0]          ier;
    logic                fifo_en;
    logic [1:0]          trig;
    logic [7:0]          lcr;
    logic [7:0]          mcr;
    logic [7:0]          scr;
    logic [15:0]         div;
    logic                cts_prev;
    logic                dcts;
    logic                oe;
    logic                rts_hold;
    logic                rts_n;
    logic                dtr_n;
    logic                txdma_n;
    logic                rxdma_n;
    uaf_tx_state_t       tx_state;
    logic [5:0]          tx_cnt;
    logic [2:0]          tx_bit;
    logic [7:0]          tx_shift;
    logic                tx_par;
    logic                tx_line;
    uaf_rx_state_t       rx_state;
    logic [5:0]          rx_cnt;
    logic [2:0]          rx_bit;
    logic [7:0]          rx_shift;
    logic                rx_pe;
  } uaf_core_st_t;

  uaf_core_st_t     q;
  uaf_core_st_t     d;
  logic             tick;
  logic             rx_flush;
  logic             rx_push;
  logic [RX_W-1:0]  rx_wdata;
  logic             rx_pop;
  logic [RX_W-1:0]  rx_head;
  logic [CNT_W-1:0] rx_count;
  logic             tx_flush;
  logic             tx_push;
  logic             tx_pop;
  logic [7:0]       tx_head;
  logic [CNT_W-1:0] tx_count;

  // parity over the active data bits; even selects even parity
  function automatic logic par_of(input logic [7:0] data, input logic [1:0] wl, input logic even);
    logic [7:0] mask;
    mask   = 8'hff >> (2'd3 - wl);
    par_of = (^(data & mask)) ^ ~even;
  endfunction : par_of

  function automatic logic [4:0] trig_of(input logic [1:0] sel);
    case (sel)
      2'b00:   trig_of = TRIG_1;
      2'b01:   trig_of = TRIG_4;
      2'b10:   trig_of = TRIG_8;
      default: trig_of = TRIG_14;
    endcase
  endfunction : trig_of

  uaf_baud_gen u_baud (
    .i_clk     (i_clk),
    .i_rst     (i_rst),
    .i_divisor (q.div),
    .o_tick    (tick)
  );

  uaf_fifo #(.W(RX_W)) u_rx_fifo (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_flush (rx_flush),
    .i_push  (rx_push),
    .i_data  (rx_wdata),
    .i_pop   (rx_pop),
    .o_data  (rx_head),
    .o_count (rx_count)
  );

  uaf_fifo #(.W(8)) u_tx_fifo (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_flush (tx_flush),
    .i_push  (tx_push),
    .i_data  (i_avs_writedata[7:0]),
    .i_pop   (tx_pop),
    .o_data  (tx_head),
    .o_count (tx_count)
  );

  always_comb begin
    logic       req;
    logic       cap;
    logic       acc_wr;
    logic       acc_rd;
    logic [2:0] sel;
    logic       dlab;
    logic       auto_on;
    logic       cts_ok;
    logic       rx_full;
    logic       tx_full;
    logic [2:0] last_bit;
    logic [5:0] stop_len;
    logic       line;
    logic [7:0] rx_data;
    logic       fe;
    logic       first_bit;
    logic [4:0] trig;
    d         = q;
    req       = i_avs_read || i_avs_write;
    cap       = req && q.waitreq;
    acc_wr    = req && !q.waitreq && i_avs_write && i_avs_byteenable[0];
    acc_rd    = req && !q.waitreq && i_avs_read;
    sel       = i_avs_address[4:2];
    dlab      = q.lcr[LCR_DLAB_BIT];
    auto_on   = q.mcr[MCR_AFE_BIT] && q.fifo_en;
    cts_ok    = !q.mcr[MCR_AFE_BIT] || !q.fifo_en || !i_cts_n;
    line      = i_serial_input_line;
    rx_flush  = 1'b0;
    tx_flush  = 1'b0;
    rx_push   = 1'b0;
    rx_pop    = 1'b0;
    tx_push   = 1'b0;
    tx_pop    = 1'b0;
    rx_data   = '0;
    fe        = 1'b0;
    first_bit = 1'b0;
    trig      = trig_of(q.trig);
    // character mode behaves as a one-deep holding register
    rx_full   = q.fifo_en ? (rx_count == CNT_FULL) : (rx_count != '0);
    tx_full   = q.fifo_en ? (tx_count == CNT_FULL) : (tx_count != '0);
    last_bit  = 3'd4 + {1'b0, q.lcr[1:0]};
    if (!q.lcr[LCR_STOP_BIT]) begin
      stop_len = TICK_STOP1;
    end else if (q.lcr[1:0] == 2'b00) begin
      stop_len = TICK_STOP15;
    end else begin
      stop_len = TICK_STOP2;
    end
    rx_wdata  = '0;

    // bus slave: waitrequest drops for the cycle in which the access completes
    d.waitreq = !cap;
    if (cap && i_avs_read) begin
      case (sel)
        REG_DATA: d.rdata = dlab ? q.div[7:0] : rx_head[7:0];
        REG_IER:  d.rdata = dlab ? q.div[15:8] : {4'h0, q.ier};
        REG_FCR:  d.rdata = q.fifo_en ? IIR_FIFO : IIR_CHAR;
        REG_LCR:  d.rdata = q.lcr;
        REG_MCR:  d.rdata = q.mcr;
        REG_LSR:  d.rdata = {q.fifo_en && (rx_count != '0) && (rx_head[10:8] != '0),
                             (tx_count == '0) && (q.tx_state == TX_IDLE), tx_count == '0,
                             rx_head[10:8] & {3{rx_count != '0}}, q.oe, rx_count != '0};
        REG_MSR:  d.rdata = {3'h0, ~i_cts_n, 3'h0, q.dcts};
        default:  d.rdata = q.scr;
      endcase
    end

    if (acc_wr) begin
      case (sel)
        REG_DATA: begin
          if (dlab) begin
            d.div[7:0] = i_avs_writedata[7:0];
          end else begin
            tx_push = !tx_full;
          end
        end
        REG_IER: begin
          if (dlab) begin
            d.div[15:8] = i_avs_writedata[7:0];
          end else begin
            d.ier = i_avs_writedata[3:0];
          end
        end
        REG_FCR: begin
          d.fifo_en = i_avs_writedata[FCR_EN_BIT];
          d.trig    = i_avs_writedata[7:6];
          rx_flush  = i_avs_writedata[FCR_RXR_BIT] || (d.fifo_en != q.fifo_en);
          tx_flush  = i_avs_writedata[FCR_TXR_BIT] || (d.fifo_en != q.fifo_en);
        end
        REG_LCR: d.lcr = i_avs_writedata[7:0];
        REG_MCR: d.mcr = i_avs_writedata[7:0] & MCR_MASK;
        REG_SCR: d.scr = i_avs_writedata[7:0];
        default: d.scr = q.scr;
      endcase
    end

    if (acc_rd && sel == REG_DATA && !dlab) begin
      rx_pop = 1'b1;
    end
    // overrun clears on read unless a new one lands the same cycle
    if (acc_rd && sel == REG_LSR) begin
      d.oe = q.oe & ~q.rdata[1];
    end

    // change flag only records; this block drives no interrupt line
    d.cts_prev = i_cts_n;
    d.dcts     = (acc_rd && sel == REG_MSR) ? (q.dcts & ~q.rdata[MSR_DCTS_BIT]) : q.dcts;
    if (i_cts_n != q.cts_prev) begin
      d.dcts = 1'b1;
    end

    // transmitter; CTS is looked at only while idle, before each byte
    case (q.tx_state)
      TX_IDLE: begin
        d.tx_line = 1'b1;
        if (tx_count != '0 && cts_ok) begin
          tx_pop     = 1'b1;
          d.tx_shift = tx_head;
          d.tx_par   = par_of(tx_head, q.lcr[1:0], q.lcr[LCR_EPS_BIT]);
          d.tx_cnt   = '0;
          d.tx_bit   = '0;
          d.tx_line  = 1'b0;
          d.tx_state = TX_START;
        end
      end
      TX_START, TX_DATA, TX_PAR: begin
        if (tick) begin
          d.tx_cnt = q.tx_cnt + 6'h01;
          if (q.tx_cnt == TICK_BIT - 6'h01) begin
            d.tx_cnt = '0;
            if (q.tx_state == TX_START) begin
              d.tx_line  = q.tx_shift[0];
              d.tx_state = TX_DATA;
            end else if (q.tx_state == TX_DATA && q.tx_bit != last_bit) begin
              d.tx_shift = {1'b0, q.tx_shift[7:1]};
              d.tx_line  = q.tx_shift[1];
              d.tx_bit   = q.tx_bit + 3'd1;
            end else if (q.tx_state == TX_DATA && q.lcr[LCR_PEN_BIT]) begin
              d.tx_line  = q.tx_par;
              d.tx_state = TX_PAR;
            end else begin
              d.tx_line  = 1'b1;
              d.tx_state = TX_STOP;
            end
          end
        end
      end
      TX_STOP: begin
        if (tick) begin
          d.tx_cnt = q.tx_cnt + 6'h01;
          if (q.tx_cnt == stop_len - 6'h01) begin
            d.tx_state = TX_IDLE;
          end
        end
      end
      default: d.tx_state = TX_IDLE;
    endcase

    // receiver; start bit is rechecked at its middle to reject glitches
    case (q.rx_state)
      RX_IDLE: begin
        if (!line) begin
          d.rx_cnt   = '0;
          d.rx_bit   = '0;
          d.rx_state = RX_START;
        end
      end
      RX_START: begin
        if (tick) begin
          d.rx_cnt = q.rx_cnt + 6'h01;
          if (q.rx_cnt == TICK_HALF - 6'h01) begin
            d.rx_cnt   = '0;
            d.rx_state = line ? RX_IDLE : RX_DATA;
          end
        end
      end
      RX_DATA, RX_PAR, RX_STOP: begin
        if (tick) begin
          d.rx_cnt = q.rx_cnt + 6'h01;
          if (q.rx_state == RX_DATA && q.rx_bit == 3'd0 && q.rx_cnt == TICK_HALF - 6'h01) begin
            first_bit = 1'b1;
          end
          if (q.rx_cnt == TICK_BIT - 6'h01) begin
            d.rx_cnt = '0;
            if (q.rx_state == RX_DATA) begin
              d.rx_shift = {line, q.rx_shift[7:1]};
              d.rx_bit   = q.rx_bit + 3'd1;
              if (q.rx_bit == last_bit) begin
                d.rx_state = q.lcr[LCR_PEN_BIT] ? RX_PAR : RX_STOP;
              end
            end else if (q.rx_state == RX_PAR) begin
              rx_data    = q.rx_shift >> (2'd3 - q.lcr[1:0]);
              d.rx_pe    = line != par_of(rx_data, q.lcr[1:0], q.lcr[LCR_EPS_BIT]);
              d.rx_state = RX_STOP;
            end else begin
              rx_data    = q.rx_shift >> (2'd3 - q.lcr[1:0]);
              fe         = !line;
              rx_wdata   = {fe && (rx_data == '0), fe, q.rx_pe && q.lcr[LCR_PEN_BIT], rx_data};
              // a byte arriving after RTS dropped is still stored while room remains
              rx_push    = !rx_full;
              d.oe       = d.oe | rx_full;
              d.rx_pe    = 1'b0;
              d.rx_state = RX_IDLE;
            end
          end
        end
      end
      default: d.rx_state = RX_IDLE;
    endcase

    // auto-RTS hold state
    if (q.trig != 2'b11) begin
      if (rx_count >= trig) begin
        d.rts_hold = 1'b1;
      end else if (rx_count == '0) begin
        d.rts_hold = 1'b0;
      end
    end else begin
      if (rx_pop && rx_count == CNT_FULL) begin
        d.rts_hold = 1'b0;
      end else if (rx_count == CNT_FULL || (first_bit && rx_count == CNT_HI14)) begin
        d.rts_hold = 1'b1;
      end else if (rx_count < CNT_HI14 || (rx_count == CNT_HI14 && q.rx_state == RX_IDLE)) begin
        d.rts_hold = 1'b0;
      end
    end

    // RTS pin follows MCR bit 1, gated by the hold only in auto mode
    d.rts_n   = ~(d.mcr[MCR_RTS_BIT] && !(auto_on && d.rts_hold));
    d.dtr_n   = ~d.mcr[MCR_DTR_BIT];
    d.txdma_n = !(tx_count == '0);
    d.rxdma_n = !(rx_count != '0);
    d.tx_line = d.tx_line && !d.lcr[LCR_BRK_BIT];
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      q          <= '0;
      q.waitreq  <= 1'b1;
      q.lcr      <= LCR_RST;
      q.mcr      <= MCR_RST;
      q.div      <= DIV_RST;
      q.cts_prev <= 1'b1;
      q.rts_n    <= 1'b1;
      q.dtr_n    <= 1'b1;
      q.txdma_n  <= 1'b1;
      q.rxdma_n  <= 1'b1;
      q.tx_line  <= 1'b1;
      q.tx_state <= TX_IDLE;
      q.rx_state <= RX_IDLE;
    end else begin
      q <= d;
    end
  end

  assign o_avs_readdata       = {24'h000000, q.rdata};
  assign o_avs_waitrequest    = q.waitreq;
  assign o_serial_output_line = q.tx_line;
  assign o_rts_n              = q.rts_n;
  assign o_dtr_n              = q.dtr_n;
  assign o_tx_dma_request_n   = q.txdma_n;
  assign o_rx_dma_request_n   = q.rxdma_n;
  assign o_baud_clock_output  = tick;

endmodule : uaf_core

// >>> verilog/uaf_fifo.sv
`timescale 1ns/10ps
module uaf_fifo
  import uaf_pkg::*;
#(
  parameter int W = 8
) (
  // clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_rst,
  // control
  input  wire logic             i_flush,
  input  wire logic             i_push,
  input  wire logic [W-1:0]     i_data,
  input  wire logic             i_pop,
  // status
  output logic      [W-1:0]     o_data,
  output logic      [CNT_W-1:0] o_count
);

  typedef struct packed {
    logic [FIFO_DEPTH-1:0][W-1:0] mem;
    logic [FIFO_AW-1:0]           wr;
    logic [FIFO_AW-1:0]           rd;
    logic [CNT_W-1:0]             cnt;
  } uaf_fifo_st_t;

  uaf_fifo_st_t q;
  uaf_fifo_st_t d;
  logic         push_ok;
  logic         pop_ok;

  always_comb begin
    d       = q;
    push_ok = i_push && (q.cnt != CNT_FULL);
    pop_ok  = i_pop && (q.cnt != '0);
    if (i_flush) begin
      d.wr  = '0;
      d.rd  = '0;
      d.cnt = '0;
    end else begin
      if (push_ok) begin
        d.mem[q.wr] = i_data;
        d.wr        = q.wr + 1'b1;
      end
      if (pop_ok) begin
        d.rd = q.rd + 1'b1;
      end
      d.cnt = CNT_W'(q.cnt + {4'h0, push_ok} - {4'h0, pop_ok});
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign o_data  = q.mem[q.rd];
  assign o_count = q.cnt;

endmodule : uaf_fifo

// >>> verilog/uaf_pkg.sv
package uaf_pkg;

  // register word indices; byte address is index times four
  localparam logic [2:0] REG_DATA = 3'h0;
  localparam logic [2:0] REG_IER  = 3'h1;
  localparam logic [2:0] REG_FCR  = 3'h2;
  localparam logic [2:0] REG_LCR  = 3'h3;
  localparam logic [2:0] REG_MCR  = 3'h4;
  localparam logic [2:0] REG_LSR  = 3'h5;
  localparam logic [2:0] REG_MSR  = 3'h6;
  localparam logic [2:0] REG_SCR  = 3'h7;

  // field positions
  localparam int MCR_DTR_BIT  = 0;
  localparam int MCR_RTS_BIT  = 1;
  localparam int MCR_AFE_BIT  = 5;
  localparam int LCR_STOP_BIT = 2;
  localparam int LCR_PEN_BIT  = 3;
  localparam int LCR_EPS_BIT  = 4;
  localparam int LCR_BRK_BIT  = 6;
  localparam int LCR_DLAB_BIT = 7;
  localparam int FCR_EN_BIT   = 0;
  localparam int FCR_RXR_BIT  = 1;
  localparam int FCR_TXR_BIT  = 2;
  localparam int MSR_DCTS_BIT = 0;
  localparam int MSR_CTS_BIT  = 4;

  // reset values and masks
  localparam logic [7:0]  LCR_RST   = 8'h00;
  localparam logic [7:0]  MCR_RST   = 8'h00;
  localparam logic [7:0]  MCR_MASK  = 8'h23;
  localparam logic [15:0] DIV_RST   = 16'h0000;
  localparam logic [7:0]  IIR_CHAR  = 8'h01;
  localparam logic [7:0]  IIR_FIFO  = 8'hc1;

  // fifo geometry and trigger levels
  localparam int          FIFO_DEPTH = 16;
  localparam int          FIFO_AW    = 4;
  localparam int          CNT_W      = 5;
  localparam int          RX_W       = 11;
  localparam logic [4:0]  CNT_FULL   = 5'h10;
  localparam logic [4:0]  CNT_HI14   = 5'h0f;
  localparam logic [4:0]  TRIG_1     = 5'h01;
  localparam logic [4:0]  TRIG_4     = 5'h04;
  localparam logic [4:0]  TRIG_8     = 5'h08;
  localparam logic [4:0]  TRIG_14    = 5'h0e;

  // timing in 16x ticks
  localparam logic [5:0]  TICK_BIT   = 6'h10;
  localparam logic [5:0]  TICK_HALF  = 6'h08;
  localparam logic [5:0]  TICK_STOP1 = 6'h10;
  localparam logic [5:0]  TICK_STOP15 = 6'h18;
  localparam logic [5:0]  TICK_STOP2 = 6'h20;

  typedef enum logic [2:0] {
    TX_IDLE  = 3'b000,
    TX_START = 3'b001,
    TX_DATA  = 3'b010,
    TX_PAR   = 3'b011,
    TX_STOP  = 3'b100
  } uaf_tx_state_t;

  typedef enum logic [2:0] {
    RX_IDLE  = 3'b000,
    RX_START = 3'b001,
    RX_DATA  = 3'b010,
    RX_PAR   = 3'b011,
    RX_STOP  = 3'b100
  } uaf_rx_state_t;

endpackage : uaf_pkg
